// file: stm_cfg.svh
// Constants of the standard timer mode engine: codes and reset values.
// Assumes inclusion by bare name from the design modules.
`ifndef STM_CFG_SVH
`define STM_CFG_SVH

// ****************************************************************
// Mode select codes
// ****************************************************************
`define STM_MODE_COMPARE   2'b00
`define STM_MODE_UNDEF     2'b01
`define STM_MODE_PWM_PULSE 2'b10
`define STM_MODE_COUNTER   2'b11

// ****************************************************************
// Pin action codes
// ****************************************************************
`define STM_ACT_NONE       2'b00
`define STM_ACT_LOW        2'b01
`define STM_ACT_HIGH       2'b10
`define STM_ACT_TOGGLE     2'b11
`define STM_PWM_INACTIVE   2'b00
`define STM_PWM_ACTIVE     2'b01
`define STM_PWM_WAVE       2'b10
`define STM_PULSE_SEL      2'b11

// ****************************************************************
// Reset values
// ****************************************************************
`define STM_RST_COUNT      16'h0000
`define STM_RST_FLAG       1'b0
`define STM_RST_RUN        1'b0
`define STM_RST_PIN        1'b0

`endif

// file: stm_core_if.sv
// Link between the mode control and the counter core.
// Assumes both ends run on the same core clock.
interface stm_core_if #(
  parameter int CNT_W = 16,
  parameter int P_W   = 8
);
  logic             tick;
  logic             run;
  logic             restart;
  logic             clearHit;
  logic [CNT_W-1:0] cmpA;
  logic [P_W-1:0]   cmpP;
  logic [CNT_W-1:0] count;
  logic             matchA;
  logic             matchP;

  modport core (
    input  tick,
    input  run,
    input  restart,
    input  clearHit,
    input  cmpA,
    input  cmpP,
    output count,
    output matchA,
    output matchP
  );

  modport ctrl (
    output tick,
    output run,
    output restart,
    output clearHit,
    output cmpA,
    output cmpP,
    input  count,
    input  matchA,
    input  matchP
  );
endinterface : stm_core_if

// file: stm_counter_core.sv
// Up-counter with the two comparators of the standard timer.
// Assumes tick is a one-cycle enable from the clock selection outside.
`include "stm_cfg.svh"
module stm_counter_core
  import stm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int P_W   = 8
)(
  input wire logic core_clk,
  input wire logic nrst,
  stm_core_if.core bus
);

  localparam int LOW_W = CNT_W - P_W;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W:0]   incrWide;
  logic [P_W:0]     pTarget;

  // ****************************************************************
  // Comparators on the value the counter is about to reach
  // ****************************************************************
  assign incrWide    = {1'b0, count_reg} + {{CNT_W{1'b0}}, 1'b1};
  assign pTarget     = (bus.cmpP == '0) ? {1'b1, {P_W{1'b0}}} : {1'b0, bus.cmpP};
  assign bus.matchA  = (incrWide == {1'b0, bus.cmpA});
  assign bus.matchP  = (incrWide[CNT_W:LOW_W] == pTarget) &&
                       (incrWide[LOW_W-1:0] == '0);

  // ****************************************************************
  // Count
  // ****************************************************************
  assign count_next = bus.restart ? '0 :
                      (bus.tick && bus.run) ?
                      (bus.clearHit ? '0 : incrWide[CNT_W-1:0]) : count_reg;
  assign bus.count  = count_reg;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      count_reg <= `STM_RST_COUNT;
    else
      count_reg <= count_next;
  end

endmodule : stm_counter_core

// file: stm_mode_engine.sv
// Operating-mode logic of the standard timer: compare, counter, PWM, single pulse.
// Assumes control bits and the trigger pin are synchronous to core_clk and that
// timerClkEn is a one-cycle pulse of the selected counter clock.
`include "stm_cfg.svh"
module stm_mode_engine
  import stm_pkg::*;
#(
  parameter int CNT_W = 16,
  parameter int P_W   = 8
)(
  input  wire logic             core_clk,
  input  wire logic             nrst,
  input  wire logic             timerClkEn,
  input  wire logic             modeSelectHi,
  input  wire logic             modeSelectLo,
  input  wire logic             pinActionHi,
  input  wire logic             pinActionLo,
  input  wire logic             outputInitialLevel,
  input  wire logic             outputInvert,
  input  wire logic             dutyPeriodSwap,
  input  wire logic             clearSourceSelect,
  input  wire logic             counterRunWrite,
  input  wire logic             counterRunData,
  input  wire logic [CNT_W-1:0] compareAValue,
  input  wire logic [P_W-1:0]   comparePValue,
  input  wire logic             externalTriggerPin,
  input  wire logic             triggerFallingEdge,
  input  wire logic             matchAFlagClear,
  input  wire logic             matchPFlagClear,
  output logic                  counterRun,
  output logic [CNT_W-1:0]      counterValue,
  output logic                  matchAFlag,
  output logic                  matchPFlag,
  output logic                  timerOutputPin,
  output logic                  timerOutputPinEn
);

  localparam int LOW_W = CNT_W - P_W;

  stm_core_if #(.CNT_W(CNT_W), .P_W(P_W)) coreBus ();

  logic [1:0]       modeBits;
  logic [1:0]       actBits;
  stm_mode_type     modeSel;
  logic             cmpLike;
  logic             trigEdge;
  logic             runRise;
  logic             tickRun;
  logic             aHit;
  logic             pHit;
  logic             periodHit;
  logic [CNT_W:0]   pScaled;
  logic [CNT_W:0]   aWide;
  logic [CNT_W:0]   dutyWide;
  logic [CNT_W:0]   periodWide;
  logic             waveActive;
  logic             activeLevel;
  logic             setA;
  logic             setP;
  logic             cmpLevelHit;
  logic             rawPin;
  logic             counterRun_reg;
  logic             counterRun_next;
  logic             runPrev_reg;
  logic             matchAFlag_reg;
  logic             matchAFlag_next;
  logic             matchPFlag_reg;
  logic             matchPFlag_next;
  logic             cmpLevel_reg;
  logic             cmpLevel_next;
  logic             pin_reg;
  logic             pin_next;
  logic             pinEn_reg;
  logic             pinEn_next;

  // ****************************************************************
  // Mode decode
  // ****************************************************************
  assign modeBits = {modeSelectHi, modeSelectLo};
  assign actBits  = {pinActionHi, pinActionLo};
  assign modeSel  = (modeBits == `STM_MODE_COMPARE) ? STM_M_COMPARE :
                    (modeBits != `STM_MODE_PWM_PULSE) ? STM_M_COUNTER :
                    (actBits == `STM_PULSE_SEL) ? STM_M_PULSE : STM_M_PWM;
  assign cmpLike  = (modeSel == STM_M_COMPARE) || (modeSel == STM_M_COUNTER);

  // ****************************************************************
  // Counter core and trigger
  // ****************************************************************
  stm_counter_core #(.CNT_W(CNT_W), .P_W(P_W)) stm_counter_core_inst (
    .core_clk (core_clk),
    .nrst     (nrst),
    .bus      (coreBus.core)
  );

  stm_trig_edge stm_trig_edge_inst (
    .core_clk   (core_clk),
    .nrst       (nrst),
    .trigPin    (externalTriggerPin),
    .fallingSel (triggerFallingEdge),
    .trigEdge   (trigEdge)
  );

  assign runRise   = counterRun_reg && !runPrev_reg;
  assign tickRun   = timerClkEn && counterRun_reg;
  assign aHit      = tickRun && coreBus.matchA;
  assign pHit      = tickRun && coreBus.matchP;
  assign periodHit = dutyPeriodSwap ? aHit : pHit;

  assign coreBus.tick     = timerClkEn;
  assign coreBus.run      = counterRun_reg;
  assign coreBus.restart  = runRise;
  assign coreBus.cmpA     = compareAValue;
  assign coreBus.cmpP     = comparePValue;
  assign coreBus.clearHit = (modeSel == STM_M_PWM) ? periodHit :
                            (modeSel == STM_M_PULSE) ? 1'b0 :
                            (clearSourceSelect ? aHit : pHit);

  // ****************************************************************
  // Duty and period
  // ****************************************************************
  assign pScaled    = (comparePValue == '0) ? {1'b1, {CNT_W{1'b0}}} :
                      {1'b0, comparePValue, {LOW_W{1'b0}}};
  assign aWide      = (compareAValue == '0) ? {1'b1, {CNT_W{1'b0}}} :
                      {1'b0, compareAValue};
  assign dutyWide   = dutyPeriodSwap ? pScaled : {1'b0, compareAValue};
  assign periodWide = dutyPeriodSwap ? aWide : pScaled;
  assign waveActive = counterRun_reg &&
                      (({1'b0, coreBus.count} < dutyWide) || (dutyWide >= periodWide));

  // ****************************************************************
  // Run bit
  // ****************************************************************
  assign counterRun_next = ((modeSel == STM_M_PULSE) && aHit) ? 1'b0 :
                           ((modeSel == STM_M_PULSE) && trigEdge) ? 1'b1 :
                           counterRunWrite ? counterRunData : counterRun_reg;

  // ****************************************************************
  // Flags, set wins over clear
  // ****************************************************************
  assign setA = aHit;
  assign setP = pHit && ((modeSel == STM_M_PWM) || (cmpLike && !clearSourceSelect));
  assign matchAFlag_next = setA || (matchAFlag_reg && !matchAFlagClear);
  assign matchPFlag_next = setP || (matchPFlag_reg && !matchPFlagClear);

  // ****************************************************************
  // Compare mode pin level
  // ****************************************************************
  assign cmpLevelHit = (modeSel == STM_M_COMPARE) && setA;

  always_comb
  begin
    cmpLevel_next = cmpLevel_reg;
    if (runRise)
      cmpLevel_next = outputInitialLevel;
    else if (cmpLevelHit)
    begin
      unique case (actBits)
        `STM_ACT_NONE:   cmpLevel_next = cmpLevel_reg;
        `STM_ACT_LOW:    cmpLevel_next = 1'b0;
        `STM_ACT_HIGH:   cmpLevel_next = 1'b1;
        `STM_ACT_TOGGLE: cmpLevel_next = !cmpLevel_reg;
      endcase
    end
  end

  // ****************************************************************
  // Output pin
  // ****************************************************************
  always_comb
  begin
    activeLevel = 1'b0;
    unique case (actBits)
      `STM_PWM_INACTIVE: activeLevel = 1'b0;
      `STM_PWM_ACTIVE:   activeLevel = 1'b1;
      `STM_PWM_WAVE:     activeLevel = waveActive;
      `STM_PULSE_SEL:    activeLevel = counterRun_reg;
    endcase
  end

  always_comb
  begin
    rawPin = 1'b0;
    unique case (modeSel)
      STM_M_COMPARE: rawPin = cmpLevel_reg;
      STM_M_PWM:     rawPin = activeLevel ? outputInitialLevel : !outputInitialLevel;
      STM_M_PULSE:   rawPin = activeLevel ? outputInitialLevel : !outputInitialLevel;
      STM_M_COUNTER: rawPin = 1'b0;
    endcase
  end

  assign pin_next   = (modeSel == STM_M_COUNTER) ? 1'b0 : (rawPin ^ outputInvert);
  assign pinEn_next = (modeSel != STM_M_COUNTER);

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      counterRun_reg <= `STM_RST_RUN;
      runPrev_reg    <= `STM_RST_RUN;
      matchAFlag_reg <= `STM_RST_FLAG;
      matchPFlag_reg <= `STM_RST_FLAG;
      cmpLevel_reg   <= `STM_RST_PIN;
      pin_reg        <= `STM_RST_PIN;
      pinEn_reg      <= 1'b0;
    end
    else
    begin
      counterRun_reg <= counterRun_next;
      runPrev_reg    <= counterRun_reg;
      matchAFlag_reg <= matchAFlag_next;
      matchPFlag_reg <= matchPFlag_next;
      cmpLevel_reg   <= cmpLevel_next;
      pin_reg        <= pin_next;
      pinEn_reg      <= pinEn_next;
    end
  end

  assign counterRun       = counterRun_reg;
  assign counterValue     = coreBus.count;
  assign matchAFlag       = matchAFlag_reg;
  assign matchPFlag       = matchPFlag_reg;
  assign timerOutputPin   = pin_reg;
  assign timerOutputPinEn = pinEn_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_trigStart;
    (modeSel == STM_M_PULSE) && trigEdge && !aHit && !counterRun_reg;
  endsequence

  sequence s_pulseOn;
    (counterRun_reg && runRise) ##1 (coreBus.count == '0);
  endsequence

  property p_tc_flag;
    (modeSel == STM_M_COUNTER) && aHit |=> matchAFlag_reg;
  endproperty
  property p_tc_nodrive;
    (modeSel == STM_M_COUNTER) |=> !pinEn_reg && !pin_reg;
  endproperty
  property p_pwm_wave;
    (modeSel == STM_M_PWM) && (actBits == `STM_PWM_WAVE) && !$stable(waveActive)
      |=> pin_reg == (($past(waveActive) ? $past(outputInitialLevel) :
                       !$past(outputInitialLevel)) ^ $past(outputInvert));
  endproperty
  property p_full_duty;
    (modeSel == STM_M_PWM) && (actBits == `STM_PWM_WAVE) && counterRun_reg &&
      (dutyWide >= periodWide) && $stable(outputInvert) && $stable(outputInitialLevel)
      |=> pin_reg == ($past(outputInitialLevel) ^ $past(outputInvert));
  endproperty
  property p_period_clear;
    (modeSel == STM_M_PWM) && periodHit && !runRise |=> coreBus.count == '0;
  endproperty
  property p_pwm_flags;
    (modeSel == STM_M_PWM) |-> ((aHit |=> matchAFlag_reg) and (pHit |=> matchPFlag_reg));
  endproperty
  property p_force;
    (modeSel == STM_M_PWM) && (actBits == `STM_PWM_ACTIVE) && $stable(outputInitialLevel)
      && $stable(outputInvert) |=> pin_reg == ($past(outputInitialLevel) ^ $past(outputInvert));
  endproperty
  property p_trig_start;
    s_trigStart |=> s_pulseOn;
  endproperty
  property p_pulse_end;
    (modeSel == STM_M_PULSE) && aHit |=> !counterRun_reg ##1
      (pin_reg == (!outputInitialLevel ^ outputInvert)) || (modeSel != STM_M_PULSE);
  endproperty
  property p_pulse_flag;
    (modeSel == STM_M_PULSE) && aHit |=> matchAFlag_reg;
  endproperty
  property p_pulse_hold;
    (modeSel == STM_M_PULSE) && !runRise && !tickRun |=> $stable(coreBus.count);
  endproperty
  property p_no_pflag;
    cmpLike && clearSourceSelect && !matchPFlag_reg |=> !matchPFlag_reg;
  endproperty
  property p_init_level;
    (modeSel == STM_M_COMPARE) && runRise |=> cmpLevel_reg == $past(outputInitialLevel);
  endproperty
  property p_cmp_quiet;
    !runRise && !cmpLevelHit |=> $stable(cmpLevel_reg);
  endproperty
  property p_toggle;
    cmpLevelHit && !runRise && (actBits == `STM_ACT_TOGGLE) |=> !$stable(cmpLevel_reg);
  endproperty

  a_tc_flag:      assert property (p_tc_flag) else $error("A flag missed in counter mode");
  a_tc_nodrive:   assert property (p_tc_nodrive) else $error("Pin driven in counter mode");
  a_pwm_wave:     assert property (p_pwm_wave) else $error("PWM pin level wrong");
  a_full_duty:    assert property (p_full_duty) else $error("Full duty not active");
  a_period_clear: assert property (p_period_clear) else $error("Period did not clear");
  a_pwm_flags:    assert property (p_pwm_flags) else $error("PWM flags missing");
  a_force:        assert property (p_force) else $error("Forced active level wrong");
  a_trig_start:   assert property (p_trig_start) else $error("Trigger did not start");
  a_pulse_end:    assert property (p_pulse_end) else $error("A match did not end pulse");
  a_pulse_flag:   assert property (p_pulse_flag) else $error("Pulse A flag missing");
  a_pulse_hold:   assert property (p_pulse_hold) else $error("Pulse counter moved");
  a_no_pflag:     assert property (p_no_pflag) else $error("P flag set with A clear");
  a_init_level:   assert property (p_init_level) else $error("Initial level not set");
  a_cmp_quiet:    assert property (p_cmp_quiet) else $error("Compare pin moved");
  a_toggle:       assert property (p_toggle) else $error("Toggle did not toggle");

endmodule : stm_mode_engine

// file: stm_mode_engine_end.sv
// Holds no logic of its own; the mode engine and its two submodules stand elsewhere.
// Assumes nothing of its surroundings.

// file: stm_mode_engine_tb_top.sv
// Self-checking bench of the standard timer mode engine.
// Assumes the design package and header are compiled first.
module stm_mode_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        core_clk, nrst, timerClkEn, modeSelectHi, modeSelectLo, pinActionHi;
  logic        pinActionLo, outputInitialLevel, outputInvert, dutyPeriodSwap;
  logic        clearSourceSelect, counterRunWrite, counterRunData, externalTriggerPin;
  logic        triggerFallingEdge, matchAFlagClear, matchPFlagClear, fire;
  logic [15:0] compareAValue;
  logic [7:0]  comparePValue;
  logic        counterRun, matchAFlag, matchPFlag, timerOutputPin, timerOutputPinEn;
  logic [15:0] counterValue;
  int          failures = 0;
  int          nTests = 0;
  int          cycles = 0;

  stm_mode_engine stm_mode_engine_inst (.core_clk(core_clk), .nrst(nrst),
    .timerClkEn(timerClkEn), .modeSelectHi(modeSelectHi), .modeSelectLo(modeSelectLo),
    .pinActionHi(pinActionHi), .pinActionLo(pinActionLo),
    .outputInitialLevel(outputInitialLevel), .outputInvert(outputInvert),
    .dutyPeriodSwap(dutyPeriodSwap), .clearSourceSelect(clearSourceSelect),
    .counterRunWrite(counterRunWrite), .counterRunData(counterRunData),
    .compareAValue(compareAValue), .comparePValue(comparePValue),
    .externalTriggerPin(externalTriggerPin), .triggerFallingEdge(triggerFallingEdge),
    .matchAFlagClear(matchAFlagClear), .matchPFlagClear(matchPFlagClear),
    .counterRun(counterRun), .counterValue(counterValue), .matchAFlag(matchAFlag),
    .matchPFlag(matchPFlag), .timerOutputPin(timerOutputPin),
    .timerOutputPinEn(timerOutputPinEn));

  stm_trig_partner stm_trig_partner_inst (.core_clk(core_clk), .fire(fire),
    .fallingSel(triggerFallingEdge), .trigPin(externalTriggerPin));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", nTests, failures);
    if (failures == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim

  task automatic cfg(input logic [1:0] m, input logic [1:0] a, input logic lvl,
                     input logic inv, input logic swp, input logic clr,
                     input logic [15:0] av, input logic [7:0] pv);
    @(negedge core_clk);
    {modeSelectHi, modeSelectLo, pinActionHi, pinActionLo} = {m, a};
    {outputInitialLevel, outputInvert, dutyPeriodSwap, clearSourceSelect} = {lvl, inv, swp, clr};
    compareAValue = av;
    comparePValue = pv;
  endtask : cfg

  task automatic run(input logic b);
    @(negedge core_clk);
    counterRunWrite = 1'b1;
    counterRunData  = b;
    @(negedge core_clk);
    counterRunWrite = 1'b0;
  endtask : run

  task automatic clr_flags();
    @(negedge core_clk);
    {matchAFlagClear, matchPFlagClear} = 2'b11;
    @(negedge core_clk);
    {matchAFlagClear, matchPFlagClear} = 2'b00;
  endtask : clr_flags

  task automatic cnt(input int n, output int h);
    h = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      if (timerOutputPin === 1'b1)
        h++;
    end
  endtask : cnt

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_clear_on_a();
    logic [15:0] mx;
    for (int m = 0; m < 4; m += (m == 0) ? 1 : 2)
    begin
      run(1'b0);
      cfg(m[1:0], 2'b11, 1'b0, 1'b0, 1'b0, 1'b1, 16'd300, 8'd1);
      clr_flags();
      run(1'b1);
      for (int i = 0; i < 700 && matchAFlag !== 1'b1; i++) @(negedge core_clk);
      mx = 16'h0000;
      repeat (310)
      begin
        @(negedge core_clk);
        if (counterValue > mx) mx = counterValue;
      end
      chk(mx, 32'd299);
      chk(matchAFlag, 1'b1);
      chk(matchPFlag, 1'b0);
      chk(timerOutputPinEn, m == 0);
    end
    $display("Clear on comparator A test done");
  endtask : t_clear_on_a

  task automatic t_compare_actions();
    logic e;
    for (int l = 0; l < 2; l++)
      for (int a = 0; a < 4; a++)
      begin
        run(1'b0);
        cfg(2'b00, a[1:0], l[0], 1'b0, 1'b0, 1'b0, 16'd5, 8'd0);
        clr_flags();
        run(1'b1);
        repeat (3) @(negedge core_clk);
        chk(timerOutputPin, l[0]);
        for (int i = 0; i < 20 && matchAFlag !== 1'b1; i++) @(negedge core_clk);
        repeat (2) @(negedge core_clk);
        e = (a == 0) ? l[0] : (a == 1) ? 1'b0 : (a == 2) ? 1'b1 : ~l[0];
        chk(timerOutputPin, e);
      end
    $display("Compare action test done");
  endtask : t_compare_actions

  task automatic t_pwm();
    int h;
    run(1'b0);
    cfg(2'b10, 2'b10, 1'b1, 1'b0, 1'b0, 1'b1, 16'd64, 8'd1);
    clr_flags();
    run(1'b1);
    for (int i = 0; i < 600 && matchPFlag !== 1'b1; i++) @(negedge core_clk);
    cnt(256, h);
    chk(h, 32'd64);
    chk(matchAFlag, 1'b1);
    chk(matchPFlag, 1'b1);
    outputInvert = 1'b1;
    cnt(256, h);
    chk(h, 32'd192);
    {outputInvert, outputInitialLevel} = 2'b00;
    cnt(256, h);
    chk(h, 32'd192);
    for (int a = 0; a < 2; a++)
    begin
      run(1'b0);
      cfg(2'b10, a[1:0], 1'b1, 1'b0, 1'b0, 1'b0, 16'd64, 8'd1);
      run(1'b1);
      clr_flags();
      cnt(300, h);
      chk(h, a * 300);
      chk(matchPFlag, 1'b1);
    end
    for (int k = 0; k < 2; k++)
    begin
      run(1'b0);
      cfg(2'b10, 2'b10, 1'b1, 1'b0, 1'b1, 1'b0, k ? 16'd100 : 16'd1000, 8'd1);
      run(1'b1);
      repeat (4) @(negedge core_clk);
      cnt(k ? 300 : 1000, h);
      chk(h, k ? 300 : 256);
    end
    $display("PWM test done");
  endtask : t_pwm

  task automatic t_pulse();
    run(1'b0);
    cfg(2'b10, 2'b11, 1'b1, 1'b0, 1'b0, 1'b0, 16'd10, 8'd0);
    clr_flags();
    run(1'b1);
    repeat (3) @(negedge core_clk);
    chk(timerOutputPin, 1'b1);
    for (int i = 0; i < 30 && counterRun !== 1'b0; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    chk(timerOutputPin, 1'b0);
    chk(matchAFlag, 1'b1);
    repeat (5) @(negedge core_clk);
    chk(counterValue, 16'd10);
    for (int f = 0; f < 2; f++)
    begin
      triggerFallingEdge = f[0];
      repeat (3) @(negedge core_clk);
      fire = 1'b1;
      @(negedge core_clk);
      fire = 1'b0;
      for (int i = 0; i < 10 && counterRun !== 1'b1; i++) @(negedge core_clk);
      repeat (2) @(negedge core_clk);
      chk(timerOutputPin, 1'b1);
      chk(counterValue < 16'd10, 1'b1);
      for (int i = 0; i < 30 && counterRun !== 1'b0; i++) @(negedge core_clk);
    end
    compareAValue = 16'd200;
    run(1'b1);
    repeat (4) @(negedge core_clk);
    run(1'b0);
    repeat (3) @(negedge core_clk);
    chk(timerOutputPin, 1'b0);
    chk(counterRun, 1'b0);
    $display("Single pulse test done");
  endtask : t_pulse

  // ****************************************************************
  // Clock, timeout and main sequence
  // ****************************************************************
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_sim();
    end
  end

  initial
  begin
    {nrst, timerClkEn, modeSelectHi, modeSelectLo, pinActionHi, pinActionLo} = 6'h10;
    {outputInitialLevel, outputInvert, dutyPeriodSwap, clearSourceSelect} = 4'h0;
    {counterRunWrite, counterRunData, triggerFallingEdge, fire} = 4'h0;
    {matchAFlagClear, matchPFlagClear} = 2'b00;
    compareAValue = 16'h0000;
    comparePValue = 8'h00;
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    t_clear_on_a();
    t_compare_actions();
    t_pwm();
    t_pulse();
    end_sim();
  end
endmodule : stm_mode_engine_tb_top

// file: stm_pkg.sv
// Types shared by the standard timer mode engine modules.
// Assumes stm_cfg.svh is on the include path.
package stm_pkg;

  // ****************************************************************
  // Operating mode, one-hot
  // ****************************************************************
  typedef enum logic [3:0]
  {
    STM_M_COMPARE = 4'b0001,
    STM_M_PWM     = 4'b0010,
    STM_M_PULSE   = 4'b0100,
    STM_M_COUNTER = 4'b1000
  } stm_mode_type;

endpackage : stm_pkg

// file: stm_trig_edge.sv
// Active edge detector for the external trigger pin.
// Assumes the pin is already synchronous to the core clock.
`include "stm_cfg.svh"
module stm_trig_edge
  import stm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic trigPin,
  input  wire logic fallingSel,
  output logic      trigEdge
);

  logic pinPrev_reg;

  // ****************************************************************
  // Edge select
  // ****************************************************************
  assign trigEdge = fallingSel ? (pinPrev_reg && !trigPin) : (!pinPrev_reg && trigPin);

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      pinPrev_reg <= 1'b0;
    else
      pinPrev_reg <= trigPin;
  end

endmodule : stm_trig_edge

// file: stm_trig_partner.sv
// Model of the party outside the trigger pin of the standard timer.
// Assumes it shares core_clk with the timer and that fire is a bench strobe.
module stm_trig_partner
(
  input  wire logic core_clk,
  input  wire logic fire,
  input  wire logic fallingSel,
  output logic      trigPin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // Pulse on the pin, idle level chosen by the active edge
  // ****************************************************************
  int hold = 0;

  initial trigPin = 1'b0;

  always @(posedge core_clk)
  begin
    if (fire)
      hold <= 3;
    else if (hold > 0)
      hold <= hold - 1;
  end

  always @(negedge core_clk)
    trigPin <= fallingSel ^ (hold > 0);
endmodule : stm_trig_partner
